// ===== common/ubgfc_defines.svh
// Constants for the baud generator and hardware flow control block
// Functional notes
// - Divisor is 22 bits: 16-bit integer plus 6-bit fraction in sixty-fourths.
// - Integer and fraction parts come from separate software-written registers.
// - Oversample select 0: divisor equals clock over sixteen times bit rate.
// - Oversample select 1: divisor equals clock over eight times bit rate.
// - Oversample tick is one-clock pulses at sixteen or eight times bit rate.
// - Transmit bit clock is oversample tick divided by sixteen or eight.
// - Fractional error stays within one sixty-fourth, spread over 64 ticks.
// - Larger divisor gives longer bit period, smaller gives shorter.
// - Request and clear flow control have independent enable bits.
// - Request output asserted while receive fill is below watermark.
// - Request output reasserts once reads bring fill below watermark.
// - Request control off: receive accepted until receive FIFO full.
// - Clear control on: sample clear input before each byte, start if asserted.
// - Clear dropping mid-character: finish the character, then stop.
// - Clear control on: send while clear asserted and data held.
// - Clear control off: send until transmit FIFO empty, ignore clear.
// - Software flow control enabled by one bit in its control register.
// - Receiver checks line on eighth tick after start edge; high is false start.
// - Accepted start: data bits sampled every sixteenth or eighth tick, per oversample select.
`ifndef UBGFC_DEFINES_SVH
`define UBGFC_DEFINES_SVH
`define UBGFC_INT_W 16
`define UBGFC_FRAC_W 6
`define UBGFC_FIFO_LVL_W 7
`define UBGFC_OVS16 5'h10
`define UBGFC_OVS8 5'h08
`define UBGFC_START_CHECK 5'h08
`define UBGFC_DATA_STEP 5'h10
`define UBGFC_INT_RESET 16'h0001
`define UBGFC_FRAC_RESET 6'h00
`endif

// ===== common/ubgfc_pkg.sv
// Types for the baud generator and hardware flow control block
package ubgfc_pkg;
    typedef enum logic [2:0] {
        UBGFC_TX_IDLE = 3'b001,
        UBGFC_TX_LOAD = 3'b010,
        UBGFC_TX_SEND = 3'b100
    } ubgfc_tx_state_t;
    typedef enum logic [2:0] {
        UBGFC_RX_IDLE = 3'b001,
        UBGFC_RX_START = 3'b010,
        UBGFC_RX_DATA = 3'b100
    } ubgfc_rx_state_t;
endpackage

// ===== design/ubgfc_top.sv
// Baud generator, bit timing and hardware flow control
`timescale 1ns/1ps
`include "ubgfc_defines.svh"
module ubgfc_top
    import ubgfc_pkg::*;
#(
    parameter int FRAME_TICKS = 10
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] integer_divisor_register,
    input wire logic [5:0] fraction_divisor_register,
    input wire logic oversample_select,
    input wire logic port_enable,
    input wire logic request_flow_enable,
    input wire logic clear_flow_enable,
    input wire logic soft_flow_enable,
    input wire logic [6:0] rx_fill_level,
    input wire logic [6:0] rx_watermark,
    input wire logic rx_fifo_full,
    input wire logic tx_fifo_empty,
    input wire logic clear_to_send_n,
    input wire logic rx_line,
    output logic request_to_send_n,
    output logic oversample_tick,
    output logic bit_tick,
    output logic tx_pop,
    output logic tx_busy,
    output logic rx_accept_en,
    output logic rx_start_valid,
    output logic rx_false_start,
    output logic rx_sample,
    output logic soft_flow_active
);
    // ------------------------------------------------------------
    // Divisor capture
    // ------------------------------------------------------------
    logic [15:0] div_int_r;
    logic [5:0] div_frac_r;
    logic [15:0] div_cnt_r;
    logic [15:0] div_cnt_nxt;
    logic [5:0] frac_acc_r;
    logic [6:0] frac_sum;
    logic stretch_r;
    logic period_end;
    logic tick_nxt;
    logic [4:0] ovs_r;
    logic [4:0] bit_cnt_r;
    logic bit_end;
    logic [15:0] div_int_safe;

    // Fractional period control
    logic [15:0] last_cnt;
    logic at_last;
    logic carry_due;
    logic stretch_set;

    // Bit clock decode
    logic [4:0] ovs_len;
    logic tick_last;

    // Ticks per bit for the selected oversampling factor
    function automatic logic [4:0] ubgfc_ovs_len(input logic sel);
        if (sel) begin
            return `UBGFC_OVS8;
        end
        return `UBGFC_OVS16;
    endfunction

    // Zero integer part would stall; treat as one
    assign div_int_safe = (integer_divisor_register == 16'h0000) ?
        16'h0001 : integer_divisor_register;

    // Registered so a software write settles before it is compared
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_int_r <= `UBGFC_INT_RESET;
        end else begin
            div_int_r <= div_int_safe;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_frac_r <= `UBGFC_FRAC_RESET;
        end else begin
            div_frac_r <= fraction_divisor_register;
        end
    end

    // ------------------------------------------------------------
    // Fractional tick generator
    // ------------------------------------------------------------
    assign frac_sum = {1'b0, frac_acc_r} + {1'b0, div_frac_r};
    // Six-bit accumulator, so any fraction code repeats every 64 ticks
    assign carry_due = frac_sum[6];
    assign last_cnt = div_int_r - 16'h0001;
    assign at_last = (div_cnt_r >= last_cnt);
    // Stretch armed one clock early so it lands in this period;
    // a divisor of one has no early clock and stretches the next
    assign stretch_set = carry_due && !stretch_r &&
        ((div_int_r == 16'h0001) || (div_cnt_r == div_int_r - 16'h0002));
    // Period is div_int clocks, plus one when the fraction carried
    assign period_end = at_last && !stretch_r;
    assign tick_nxt = period_end;
    assign div_cnt_nxt = period_end ? 16'h0000 :
        (stretch_r ? div_cnt_r : div_cnt_r + 16'h0001);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_cnt_r <= 16'h0000;
            frac_acc_r <= 6'h00;
            stretch_r <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            if (period_end) begin
                frac_acc_r <= frac_sum[5:0];
            end
            stretch_r <= stretch_set;
        end
    end

    // ------------------------------------------------------------
    // Bit clock divider
    // ------------------------------------------------------------
    // Factor decoded once and shared with the receive side
    assign ovs_len = ubgfc_ovs_len(oversample_select);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ovs_r <= `UBGFC_OVS16;
        end else begin
            ovs_r <= ovs_len;
        end
    end

    assign tick_last = (bit_cnt_r >= ovs_r - 5'h01);
    // Compare with >= so a factor cut mid-bit ends that bit at once
    assign bit_end = tick_nxt && tick_last;

    // Both pulses leave on one edge, so a bit tick is always a tick
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            oversample_tick <= 1'b0;
            bit_tick <= 1'b0;
        end else begin
            oversample_tick <= tick_nxt;
            bit_tick <= bit_end;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bit_cnt_r <= 5'h00;
        end else if (bit_end) begin
            bit_cnt_r <= 5'h00;
        end else if (tick_nxt) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // Request-to-send from receive watermark
    // ------------------------------------------------------------
    logic below_mark;
    assign below_mark = rx_fill_level < rx_watermark;

    // Level inputs, so one clock of latency is harmless
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            request_to_send_n <= 1'b1;
        end else begin
            // Far end stops after its current character
            request_to_send_n <= !(request_flow_enable ? below_mark :
                port_enable);
        end
    end

    // Only gates new start edges; a frame already running goes on unless port_enable drops
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_accept_en <= 1'b0;
        end else begin
            rx_accept_en <= port_enable && !rx_fifo_full;
        end
    end

    // ------------------------------------------------------------
    // Transmit gating by clear-to-send
    // ------------------------------------------------------------
    ubgfc_tx_state_t tx_state_r;
    logic [7:0] tx_bits_r;
    logic tx_may_start;
    logic frame_last;
    logic tx_next_byte;
    // Refused starts leave no trace; the byte simply waits
    assign tx_may_start = port_enable && !tx_fifo_empty &&
        (!clear_flow_enable || !clear_to_send_n);
    // Clear is sampled only on a bit boundary, never mid-frame
    assign tx_next_byte = bit_end && tx_may_start;
    assign frame_last = bit_end && (tx_state_r == UBGFC_TX_SEND) &&
        (tx_bits_r == 8'(FRAME_TICKS - 1));

    // Bit counter kept apart from the state register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_bits_r <= 8'h00;
        end else if (tx_state_r == UBGFC_TX_LOAD) begin
            tx_bits_r <= 8'h00;
        end else if (bit_end && tx_state_r == UBGFC_TX_SEND) begin
            tx_bits_r <= tx_bits_r + 8'h01;
        end
    end

    // A byte waiting at the closing boundary starts at once, so frames
    // abut with no idle bit between them
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_state_r <= UBGFC_TX_IDLE;
            tx_pop <= 1'b0;
            tx_busy <= 1'b0;
        end else begin
            tx_pop <= 1'b0;
            unique case (tx_state_r)
                UBGFC_TX_IDLE: begin
                    tx_busy <= 1'b0;
                    if (tx_next_byte) begin
                        tx_state_r <= UBGFC_TX_LOAD;
                        tx_pop <= 1'b1;
                        tx_busy <= 1'b1;
                    end
                end
                UBGFC_TX_LOAD: begin
                    tx_state_r <= UBGFC_TX_SEND;
                end
                UBGFC_TX_SEND: begin
                    if (frame_last && tx_next_byte) begin
                        tx_state_r <= UBGFC_TX_LOAD;
                        tx_pop <= 1'b1;
                    end else if (frame_last) begin
                        tx_state_r <= UBGFC_TX_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive start validation and bit sampling
    // ------------------------------------------------------------
    ubgfc_rx_state_t rx_state_r;
    logic [4:0] rx_tick_r;
    logic rx_line_d_r;
    logic [4:0] step;
    logic start_edge;
    logic start_due;
    logic data_due;
    assign step = ovs_len;
    // Idle-high reset value, so release of reset shows no false edge
    assign start_edge = rx_line_d_r && !rx_line && rx_accept_en;
    assign start_due = (rx_tick_r == `UBGFC_START_CHECK - 5'h01);
    assign data_due = (rx_tick_r == step - 5'h01);

    // ------------------------------------------------------------
    // Receive line edge
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_line_d_r <= 1'b1;
        end else begin
            rx_line_d_r <= rx_line;
        end
    end

    // ------------------------------------------------------------
    // Receive state machine
    // ------------------------------------------------------------

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_state_r <= UBGFC_RX_IDLE;
            rx_tick_r <= 5'h00;
            rx_start_valid <= 1'b0;
            rx_false_start <= 1'b0;
            rx_sample <= 1'b0;
        end else begin
            rx_start_valid <= 1'b0;
            rx_false_start <= 1'b0;
            rx_sample <= 1'b0;
            unique case (rx_state_r)
                UBGFC_RX_IDLE: begin
                    rx_tick_r <= 5'h00;
                    if (start_edge) begin
                        rx_state_r <= UBGFC_RX_START;
                    end
                end
                UBGFC_RX_START: begin
                    if (tick_nxt) begin
                        if (start_due) begin
                            rx_tick_r <= 5'h00;
                            if (rx_line) begin
                                rx_false_start <= 1'b1;
                                rx_state_r <= UBGFC_RX_IDLE;
                            end else begin
                                rx_start_valid <= 1'b1;
                                rx_state_r <= UBGFC_RX_DATA;
                            end
                        end else begin
                            rx_tick_r <= rx_tick_r + 5'h01;
                        end
                    end
                end
                UBGFC_RX_DATA: begin
                    if (tick_nxt) begin
                        if (data_due) begin
                            rx_tick_r <= 5'h00;
                            rx_sample <= 1'b1;
                        end else begin
                            rx_tick_r <= rx_tick_r + 5'h01;
                        end
                    end
                    // Framing is decided by the shift logic outside
                    if (!port_enable) begin
                        rx_state_r <= UBGFC_RX_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Software flow control enable
    // ------------------------------------------------------------
    // Only the enable is kept here; character matching lives elsewhere
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            soft_flow_active <= 1'b0;
        end else begin
            soft_flow_active <= soft_flow_enable;
        end
    end
endmodule

// ===== tb/ubgfc_monitor.sv
// Port-level assertions for the baud and flow control block
`timescale 1ns/1ps
module ubgfc_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] integer_divisor_register,
    input wire logic port_enable,
    input wire logic request_flow_enable,
    input wire logic clear_flow_enable,
    input wire logic [6:0] rx_fill_level,
    input wire logic [6:0] rx_watermark,
    input wire logic tx_fifo_empty,
    input wire logic clear_to_send_n,
    input wire logic request_to_send_n,
    input wire logic oversample_tick,
    input wire logic bit_tick,
    input wire logic tx_pop,
    input wire logic tx_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ----------
    // Properties
    // ----------
    sequence s_frame;
        tx_busy [*8];
    endsequence
    property p_rts_on;
        request_flow_enable && port_enable && rx_fill_level < rx_watermark
            |=> !request_to_send_n;
    endproperty
    a_rts_on: assert property (p_rts_on) else $error("rts high");
    property p_rts_off;
        request_flow_enable && port_enable && rx_fill_level >= rx_watermark
            |=> request_to_send_n;
    endproperty
    a_rts_off: assert property (p_rts_off) else $error("rts low");
    property p_rts_free;
        !request_flow_enable && port_enable |=> !request_to_send_n;
    endproperty
    a_rts_free: assert property (p_rts_free) else $error("rts");
    // Divisor one gives a tick every clock, so it is left out
    property p_tick;
        $past(integer_divisor_register) > 16'h0001 && oversample_tick
            && integer_divisor_register > 16'h0001 |=> !oversample_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick width");
    property p_bit;
        bit_tick |-> oversample_tick;
    endproperty
    a_bit: assert property (p_bit) else $error("bit tick");
    property p_cts;
        tx_pop |-> $past(!clear_flow_enable || !clear_to_send_n);
    endproperty
    a_cts: assert property (p_cts) else $error("start on cts");
    property p_fifo;
        tx_pop |-> $past(port_enable && !tx_fifo_empty);
    endproperty
    a_fifo: assert property (p_fifo) else $error("start empty");
    property p_frame;
        tx_pop |-> s_frame;
    endproperty
    a_frame: assert property (p_frame) else $error("cut frame");
endmodule

// ===== tb/ubgfc_remote.sv
// Remote serial port model facing the flow control block
`timescale 1ns/1ps
module ubgfc_remote #(
    parameter int BIT_CLKS = 32
) (
    input wire logic clk,
    input wire logic rts_n,
    input wire logic hold,
    input wire logic send_en,
    input wire logic glitch,
    output logic line,
    output logic cts_n
);
    logic [8:0] sh;
    int n = 0;
    int c = 0;
    int g = 0;
    // ----------
    // Line driver
    // ----------
    assign cts_n = hold;
    initial line = 1'b1;
    always @(posedge clk) begin
        if (n > 0) begin
            if (c > 1) begin
                c <= c - 1;
            end else begin
                line <= sh[0];
                sh <= {1'b1, sh[8:1]};
                n <= n - 1;
                c <= BIT_CLKS;
            end
        end else if (g > 0) begin
            line <= (g == 1);
            g <= g - 1;
        end else if (send_en && !rts_n) begin // Checked per character
            line <= 1'b0;
            sh <= {1'b1, 8'($urandom)};
            n <= 10;
            c <= BIT_CLKS;
        end else if (glitch) begin
            // Short low pulse, gone before the start check
            line <= 1'b0;
            g <= BIT_CLKS / 4;
        end
    end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the baud and flow control block
`timescale 1ns/1ps
module tb;
    logic clk, reset_n, oversample_select, port_enable, rx_line;
    logic request_flow_enable, clear_flow_enable, soft_flow_enable;
    logic [15:0] integer_divisor_register;
    logic [5:0] fraction_divisor_register;
    logic [6:0] rx_fill_level, rx_watermark;
    logic rx_fifo_full, tx_fifo_empty, clear_to_send_n, request_to_send_n;
    logic oversample_tick, bit_tick, tx_pop, tx_busy, rx_accept_en;
    logic rx_start_valid, rx_false_start, rx_sample, soft_flow_active;
    logic hold, send_en, glitch, meas;
    logic [15:0] td [4] = '{16'h0002, 16'h0002, 16'h0009, 16'h0000};
    logic [5:0] tf [4] = '{6'h00, 6'h01, 6'h3F, 6'h05};
    int num_errors, cmp_count, n_tk, clks, bits, n_pop, n_st, n_fs, n_smp;
    int exp_q[$];
    ubgfc_top u_ubgfc_top (.*);
    ubgfc_remote #(.BIT_CLKS(32)) u_ubgfc_remote (.clk(clk),
        .rts_n(request_to_send_n), .hold(hold), .send_en(send_en),
        .glitch(glitch), .line(rx_line), .cts_n(clear_to_send_n));
    // ----------
    // Helpers
    // ----------
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("ERROR at %0t: %s", $time, m);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic measure(input logic [15:0] d, input logic [5:0] f,
        input logic o);
        int dd;
        dd = (d == 16'h0000) ? 1 : int'(d);
        integer_divisor_register = d;
        fraction_divisor_register = f;
        oversample_select = o;
        wt(200);
        exp_q.push_back((dd * 64 + int'(f)) * 16 + (o ? 8 : 4));
        {n_tk, clks, bits} = '0;
        meas = 1'b1;
        while (meas) wt(1);
    endtask
    task automatic pops(input int lo, input int hi, input string m);
        wt(400);
        n_pop = 0;
        wt(700);
        chk(n_pop >= lo && n_pop <= hi, m);
    endtask
    task report_and_stop;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------
    // Watcher
    // ----------
    always @(posedge clk) begin
        n_pop += int'(tx_pop === 1'b1);
        n_st += int'(rx_start_valid === 1'b1);
        n_fs += int'(rx_false_start === 1'b1);
        n_smp += int'(rx_sample === 1'b1);
        if (meas) begin
            if (n_tk > 0) clks++;
            if (oversample_tick === 1'b1) begin
                if (n_tk > 0) bits += int'(bit_tick === 1'b1);
                n_tk++;
            end
            if (n_tk == 65) begin
                chk(clks * 16 + bits == exp_q.pop_front(), "rate");
                meas = 1'b0;
            end
        end
    end
    // ----------
    // Stimulus
    // ----------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #(30000 * 100);
        num_errors++;
        report_and_stop();
    end
    initial begin
        logic e;
        {reset_n, port_enable, request_flow_enable, clear_flow_enable} = '0;
        {soft_flow_enable, rx_fifo_full, hold, send_en, glitch, meas} = '0;
        {tx_fifo_empty, oversample_select} = 2'h2;
        {integer_divisor_register, fraction_divisor_register} = 22'h80;
        {rx_fill_level, rx_watermark} = 14'h20;
        void'($urandom(33));
        wt(4);
        reset_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i < 4) measure(td[i], tf[i], i[0]);
            else measure(16'(2 + $urandom % 8), 6'($urandom),
                1'($urandom));
        end
        measure(16'h0002, 6'h00, 1'b0);
        {port_enable, request_flow_enable, soft_flow_enable} = 3'h7;
        for (int i = 0; i < 6; i++) begin
            {rx_fill_level, rx_watermark} = 14'($urandom);
            e = rx_fill_level >= rx_watermark;
            wt(3);
            chk(request_to_send_n === e, "rts");
        end
        chk(soft_flow_active === 1'b1, "soft");
        rx_fifo_full = 1'b1;
        wt(3);
        chk(rx_accept_en === 1'b0, "accept");
        {rx_fill_level, rx_watermark, rx_fifo_full, send_en} = 16'h0021;
        {n_st, n_smp} = '0;
        wt(1000);
        chk(n_st == 1 && n_smp > 26 && n_smp < 32, "rx");
        send_en = 1'b0;
        pops(0, 0, "idle");
        port_enable = 1'b0;
        wt(3);
        {port_enable, glitch} = 2'h3;
        n_fs = 0;
        wt(1);
        glitch = 1'b0;
        wt(100);
        chk(n_fs == 1, "false start");
        {clear_flow_enable, tx_fifo_empty} = 2'h2;
        pops(2, 3, "cts low");
        hold = 1'b1;
        pops(0, 0, "cts high");
        clear_flow_enable = 1'b0;
        pops(2, 3, "cts off");
        tx_fifo_empty = 1'b1;
        pops(0, 0, "empty");
        report_and_stop();
    end
endmodule
bind ubgfc_top ubgfc_monitor u_ubgfc_monitor (.*);
